/* reset_state_cfg.svh */
// Constants for the reset state controller
`ifndef RESET_STATE_CFG_SVH
`define RESET_STATE_CFG_SVH

// Status register flag positions
`define STATUS_TIMEOUT_BIT 5
`define STATUS_POWERDOWN_BIT 4
// Control register low-voltage flag position
`define CTRL_LOWVOLT_BIT 2

// Reset values
`define PC_RESET 13'h0000
`define PCL_RESET 8'h00
`define INTC_RESET 8'h00
`define TMC_RESET 8'h00
`define PORT_RESET 8'hff
`define ANALOG_SEL_RESET 8'hff
`define STACK_TOP 3'h0
`define WDT_RESET 18'h00000

// Data memory locations of the reached registers
`define ADDR_STATUS 8'h0a
`define ADDR_PORT_A 8'h14
`define ADDR_PORT_A_DIR 8'h15
`define ADDR_PORT_B 8'h28
`define ADDR_PORT_B_DIR 8'h29
`define ADDR_PORT_C 8'h38
`define ADDR_PORT_C_DIR 8'h39
`define ADDR_PORT_D 8'h3c
`define ADDR_PORT_D_DIR 8'h3d
`define ADDR_CTRL 8'h3b
`define ADDR_INTC 8'h0b
`define ADDR_TMC 8'h40
`define ADDR_ANALOG_SEL 8'h35

// Number of ports
`define NUM_PORTS 4

`endif

/* reset_state_pkg.sv */
// Types for the reset state controller
package reset_state_pkg;

  typedef enum logic [1:0] {
    RUN_NORMAL,
    RUN_SLOW,
    HALT_IDLE,
    HALT_SLEEP
  } core_mode_type;

  typedef enum logic [2:0] {
    RST_NONE,
    RST_POWER_ON,
    RST_LOW_VOLTAGE,
    RST_WDT_RUN,
    RST_WDT_HALT
  } reset_kind_type;

  typedef struct packed {
    logic power_on;
    logic low_voltage_reset;
    logic wdt_expire;
  } reset_src_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_type;

  typedef struct packed {
    logic [12:0] pc;
    logic [7:0] pcl;
    logic [2:0] stack_ptr;
    logic [7:0] intc;
    logic [7:0] tmc;
    logic [7:0] analog_sel;
  } core_state_type;

endpackage : reset_state_pkg

/* reset_kind_decode.sv */
// Classifies asserted reset sources into one reset kind
`timescale 1ns/1ps
`include "reset_state_cfg.svh"

module reset_kind_decode
  import reset_state_pkg::*;
(
  // Sources and core mode
  input wire reset_src_type src_i,
  input wire core_mode_type mode_i,
  // Classified reset
  output reset_kind_type kind_o
);

  wire halted;
  assign halted = (mode_i == HALT_IDLE) || (mode_i == HALT_SLEEP);

  // Power-on outranks every lesser reset
  assign kind_o = src_i.power_on ? RST_POWER_ON :
                  src_i.low_voltage_reset ? RST_LOW_VOLTAGE :
                  (src_i.wdt_expire && halted) ? RST_WDT_HALT :
                  src_i.wdt_expire ? RST_WDT_RUN : RST_NONE;

endmodule : reset_kind_decode

/* reset_state_controller.sv */
// Reset state controller: flags, core state, watchdog and I/O port defaults
//
// Contract
// - Power-on clears timeout and powerdown flags
// - Low-voltage reset leaves both flags unchanged
// - Running watchdog expiry sets timeout only
// - Halted watchdog expiry sets both flags
// - Power-on disables all interrupts
// - Watchdog cleared by reset, counts immediately
// - Power-on turns all timers off
// - Non-warm reset makes ports inputs, analog pins
// - Power-on points stack at its top
// - Warm reset clears only program counter, low byte, stack pointer and watchdog
// - Port reads sample pin at second phase
// - Port output latch holds until rewritten
// - Ports reached as data memory locations
// - Power-on zeroes the program counter
// - Low-voltage flag set by low-voltage reset, software-cleared
// - Running watchdog reset equals low-voltage, setting timeout instead of the low-voltage flag
`timescale 1ns/1ps
`include "reset_state_cfg.svh"

module reset_state_controller
  import reset_state_pkg::*;
#(
  parameter int PORT_WIDTH = 8,
  parameter int WDT_WIDTH = 18
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Reset sources and core mode
  input wire reset_src_type src_i,
  input wire core_mode_type mode_i,
  // Core events
  input wire logic halt_enter_i,
  input wire logic wdt_clear_i,
  input wire logic second_clock_phase_i,
  // Data memory access
  input wire mem_req_type mem_i,
  output logic [7:0] mem_rdata_o,
  // Port pins
  input wire logic [`NUM_PORTS*PORT_WIDTH-1:0] pin_i,
  output logic [`NUM_PORTS*PORT_WIDTH-1:0] pin_o,
  output logic [`NUM_PORTS*PORT_WIDTH-1:0] pin_oe_o,
  // Status
  output logic timeout_flag_o,
  output logic powerdown_flag_o,
  output logic lowvolt_reset_flag_o,
  output core_state_type core_o,
  output logic [WDT_WIDTH-1:0] wdt_count_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [`NUM_PORTS*PORT_WIDTH-1:0] pin_meta_reg;
  logic [`NUM_PORTS*PORT_WIDTH-1:0] pin_sync_reg;

  always_ff @(posedge clk_i) begin
    pin_meta_reg <= pin_i;
    pin_sync_reg <= pin_meta_reg;
  end

  // ----------------------------------------------------------------
  // Reset classification
  // ----------------------------------------------------------------
  reset_kind_type kind;
  wire full_init;
  wire warm;

  reset_kind_decode u_decode (
    .src_i(src_i),
    .mode_i(mode_i),
    .kind_o(kind)
  );

  assign full_init = rst_i || (kind == RST_POWER_ON);
  assign warm = (kind == RST_WDT_HALT);
  wire any_reset = full_init || (kind != RST_NONE);
  wire defaults = full_init || (kind == RST_LOW_VOLTAGE) || (kind == RST_WDT_RUN);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [2:0] port_index(input logic [7:0] a);
    case (a)
      `ADDR_PORT_A, `ADDR_PORT_A_DIR: port_index = 3'd0;
      `ADDR_PORT_B, `ADDR_PORT_B_DIR: port_index = 3'd1;
      `ADDR_PORT_C, `ADDR_PORT_C_DIR: port_index = 3'd2;
      `ADDR_PORT_D, `ADDR_PORT_D_DIR: port_index = 3'd3;
      default: port_index = 3'd4;
    endcase
  endfunction : port_index

  function automatic logic is_dir(input logic [7:0] a);
    is_dir = (a == `ADDR_PORT_A_DIR) || (a == `ADDR_PORT_B_DIR) ||
             (a == `ADDR_PORT_C_DIR) || (a == `ADDR_PORT_D_DIR);
  endfunction : is_dir

  wire [2:0] sel_port = port_index(mem_i.addr);
  wire sel_dir = is_dir(mem_i.addr);
  wire sel_valid = (sel_port != 3'd4);

  // ----------------------------------------------------------------
  // Status and control flags
  // ----------------------------------------------------------------
  logic timeout_flag_reg;
  logic powerdown_flag_reg;
  logic lowvolt_reset_flag_reg;
  logic timeout_flag_next;
  logic powerdown_flag_next;
  logic lowvolt_reset_flag_next;

  wire ctrl_wr = mem_i.wr && (mem_i.addr == `ADDR_CTRL);

  always_comb begin
    timeout_flag_next = timeout_flag_reg;
    powerdown_flag_next = powerdown_flag_reg;
    if (halt_enter_i) begin
      powerdown_flag_next = 1'b1;
    end
    if (wdt_clear_i) begin
      timeout_flag_next = 1'b0;
      powerdown_flag_next = 1'b0;
    end
    case (kind)
      RST_POWER_ON: begin
        timeout_flag_next = 1'b0;
        powerdown_flag_next = 1'b0;
      end
      RST_LOW_VOLTAGE: begin
        timeout_flag_next = timeout_flag_reg;
        powerdown_flag_next = powerdown_flag_reg;
      end
      RST_WDT_RUN: begin
        timeout_flag_next = 1'b1;
        powerdown_flag_next = powerdown_flag_reg;
      end
      RST_WDT_HALT: begin
        timeout_flag_next = 1'b1;
        powerdown_flag_next = 1'b1;
      end
      default: begin
      end
    endcase
    if (rst_i) begin
      timeout_flag_next = 1'b0;
      powerdown_flag_next = 1'b0;
    end
  end

  // Set wins over a simultaneous software clear
  always_comb begin
    lowvolt_reset_flag_next = lowvolt_reset_flag_reg;
    if (ctrl_wr && !mem_i.wdata[`CTRL_LOWVOLT_BIT]) begin
      lowvolt_reset_flag_next = 1'b0;
    end
    if (kind == RST_LOW_VOLTAGE) begin
      lowvolt_reset_flag_next = 1'b1;
    end
    if (full_init) begin
      lowvolt_reset_flag_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    timeout_flag_reg <= timeout_flag_next;
    powerdown_flag_reg <= powerdown_flag_next;
    lowvolt_reset_flag_reg <= lowvolt_reset_flag_next;
  end

  // ----------------------------------------------------------------
  // Core state and watchdog
  // ----------------------------------------------------------------
  core_state_type core_reg;
  logic [WDT_WIDTH-1:0] wdt_reg;

  always_ff @(posedge clk_i) begin
    if (defaults) begin
      core_reg.pc <= `PC_RESET;
      core_reg.pcl <= `PCL_RESET;
      core_reg.stack_ptr <= `STACK_TOP;
      core_reg.intc <= `INTC_RESET;
      core_reg.tmc <= `TMC_RESET;
      core_reg.analog_sel <= `ANALOG_SEL_RESET;
    end else if (warm) begin
      core_reg.pc <= `PC_RESET;
      core_reg.pcl <= `PCL_RESET;
      core_reg.stack_ptr <= `STACK_TOP;
    end else if (mem_i.wr) begin
      if (mem_i.addr == `ADDR_INTC) core_reg.intc <= mem_i.wdata;
      if (mem_i.addr == `ADDR_TMC) core_reg.tmc <= mem_i.wdata;
      if (mem_i.addr == `ADDR_ANALOG_SEL) core_reg.analog_sel <= mem_i.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (any_reset || wdt_clear_i || halt_enter_i) begin
      wdt_reg <= WDT_WIDTH'(0);
    end else begin
      wdt_reg <= wdt_reg + WDT_WIDTH'(1);
    end
  end

  // ----------------------------------------------------------------
  // I/O ports
  // ----------------------------------------------------------------
  logic [PORT_WIDTH-1:0] data_reg [`NUM_PORTS];
  logic [PORT_WIDTH-1:0] dir_reg [`NUM_PORTS];
  logic [7:0] rdata_reg;

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < `NUM_PORTS; i++) begin
      if (defaults) begin
        data_reg[i] <= PORT_WIDTH'(`PORT_RESET);
        dir_reg[i] <= PORT_WIDTH'(`PORT_RESET);
      end else if (!warm && mem_i.wr && sel_valid && (sel_port == 3'(i))) begin
        if (sel_dir) dir_reg[i] <= PORT_WIDTH'(mem_i.wdata);
        else data_reg[i] <= PORT_WIDTH'(mem_i.wdata);
      end
    end
  end

  // Input bits read the pin, output bits read the latch
  wire [PORT_WIDTH-1:0] rd_pin = pin_sync_reg[sel_port[1:0]*PORT_WIDTH +: PORT_WIDTH];
  wire [PORT_WIDTH-1:0] rd_port = (dir_reg[sel_port[1:0]] & rd_pin) | (~dir_reg[sel_port[1:0]] & data_reg[sel_port[1:0]]);
  wire [PORT_WIDTH-1:0] rd_sel = sel_dir ? dir_reg[sel_port[1:0]] : rd_port;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 8'h00;
    end else if (mem_i.rd && second_clock_phase_i) begin
      if (sel_valid) rdata_reg <= 8'(rd_sel);
      else if (mem_i.addr == `ADDR_STATUS) begin
        rdata_reg <= 8'h00;
        rdata_reg[`STATUS_TIMEOUT_BIT] <= timeout_flag_reg;
        rdata_reg[`STATUS_POWERDOWN_BIT] <= powerdown_flag_reg;
      end else if (mem_i.addr == `ADDR_CTRL) begin
        rdata_reg <= 8'h00;
        rdata_reg[`CTRL_LOWVOLT_BIT] <= lowvolt_reset_flag_reg;
      end else rdata_reg <= 8'h00;
    end
  end

  always_comb begin
    for (int i = 0; i < `NUM_PORTS; i++) begin
      pin_o[i*PORT_WIDTH +: PORT_WIDTH] = data_reg[i];
      pin_oe_o[i*PORT_WIDTH +: PORT_WIDTH] = ~dir_reg[i];
    end
  end

  assign mem_rdata_o = rdata_reg;
  assign timeout_flag_o = timeout_flag_reg;
  assign powerdown_flag_o = powerdown_flag_reg;
  assign lowvolt_reset_flag_o = lowvolt_reset_flag_reg;
  assign core_o = core_reg;
  assign wdt_count_o = wdt_reg;

endmodule : reset_state_controller

/* reset_state_properties.sv */
// Port-level checks for the reset state controller
`timescale 1ns/1ps
`include "reset_state_cfg.svh"
module reset_state_properties
  import reset_state_pkg::*;
#(
  parameter int PORT_WIDTH = 8,
  parameter int WDT_WIDTH = 18
)
(
  // Inputs of the block
  input wire logic clk_i,
  input wire logic rst_i,
  input wire reset_src_type src_i,
  input wire core_mode_type mode_i,
  input wire logic halt_enter_i,
  input wire logic wdt_clear_i,
  input wire mem_req_type mem_i,
  // Outputs of the block
  input wire logic [`NUM_PORTS*PORT_WIDTH-1:0] pin_o,
  input wire logic [`NUM_PORTS*PORT_WIDTH-1:0] pin_oe_o,
  input wire logic timeout_flag_o,
  input wire logic powerdown_flag_o,
  input wire logic lowvolt_reset_flag_o,
  input wire core_state_type core_o,
  input wire logic [WDT_WIDTH-1:0] wdt_count_o
);
  wire lv_only = src_i.low_voltage_reset && !src_i.power_on;
  wire wdt_only = src_i == 3'h1;
  wire halted = mode_i >= HALT_IDLE;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  por_flags_a: assert property (src_i.power_on |=> !timeout_flag_o && !powerdown_flag_o)
    else $error("flags not cleared by power-on");
  lv_flags_a: assert property (lv_only |=> $stable(timeout_flag_o) && $stable(powerdown_flag_o))
    else $error("flags changed by low-voltage reset");
  wdt_run_a: assert property (wdt_only && !halted |=> timeout_flag_o && $stable(powerdown_flag_o))
    else $error("running watchdog flags wrong");
  wdt_halt_a: assert property (wdt_only && halted |=> timeout_flag_o && powerdown_flag_o)
    else $error("halted watchdog flags wrong");
  por_state_a: assert property (src_i.power_on |=> core_o.pc == `PC_RESET && core_o.intc == `INTC_RESET
    && core_o.tmc == `TMC_RESET && core_o.stack_ptr == `STACK_TOP) else $error("power-on core state wrong");
  wdt_zero_a: assert property (src_i != 3'h0 |=> wdt_count_o == '0)
    else $error("watchdog not cleared by reset");
  wdt_runs_a: assert property (src_i != 3'h0 ##1 (src_i == 3'h0 && !wdt_clear_i && !halt_enter_i) [*3]
    |-> wdt_count_o != '0) else $error("watchdog not counting after reset");
  cold_ports_a: assert property ((src_i[2:1] != 2'h0 || wdt_only && !halted) |=> pin_o == '1 && pin_oe_o == '0
    && core_o.analog_sel == `ANALOG_SEL_RESET) else $error("ports not inputs after reset");
  warm_keep_a: assert property (wdt_only && halted && !mem_i.wr |=> core_o.pc == '0 && core_o.pcl == '0
    && $stable(core_o.intc) && $stable(pin_o)) else $error("warm reset state wrong");
  lv_set_a: assert property (lv_only |=> lowvolt_reset_flag_o)
    else $error("low-voltage flag not set");
  lv_hold_a: assert property (lowvolt_reset_flag_o && !src_i.power_on && !(mem_i.wr && mem_i.addr == `ADDR_CTRL)
    |=> lowvolt_reset_flag_o) else $error("low-voltage flag lost");
  latch_hold_a: assert property (!mem_i.wr && src_i == 3'h0 |=> $stable(pin_o) && $stable(pin_oe_o))
    else $error("port latch changed without write");
  por_c: cover property (src_i.power_on);
  warm_c: cover property (wdt_only && halted);
  lv_c: cover property (lv_only);
endmodule : reset_state_properties

bind reset_state_controller reset_state_properties #(.PORT_WIDTH(PORT_WIDTH), .WDT_WIDTH(WDT_WIDTH)) props (
  .clk_i, .rst_i, .src_i, .mode_i, .halt_enter_i, .wdt_clear_i, .mem_i, .pin_o, .pin_oe_o, .timeout_flag_o,
  .powerdown_flag_o, .lowvolt_reset_flag_o, .core_o, .wdt_count_o);

/* reset_state_controller_tb.sv */
// Self-checking bench for the reset state controller
`timescale 1ns/1ps
`include "reset_state_cfg.svh"
module reset_state_controller_tb import reset_state_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  reset_src_type src_i = '0;
  core_mode_type mode_i = RUN_NORMAL;
  logic halt_enter_i = 1'b0;
  logic wdt_clear_i = 1'b0;
  logic second_clock_phase_i = 1'b0;
  mem_req_type mem_i = '0;
  logic [31:0] pin_i = 32'h0;
  logic [7:0] mem_rdata_o;
  logic [31:0] pin_o;
  logic [31:0] pin_oe_o;
  logic timeout_flag_o;
  logic powerdown_flag_o;
  logic lowvolt_reset_flag_o;
  core_state_type core_o;
  logic [17:0] wdt_count_o;
  int failures = 0;
  int checks = 0;
  wire [1:0] flags = {timeout_flag_o, powerdown_flag_o};

  reset_state_controller DUT (.clk_i, .rst_i, .src_i, .mode_i, .halt_enter_i, .wdt_clear_i, .second_clock_phase_i,
    .mem_i, .mem_rdata_o, .pin_i, .pin_o, .pin_oe_o, .timeout_flag_o, .powerdown_flag_o, .lowvolt_reset_flag_o,
    .core_o, .wdt_count_o);

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Drivers and comparison
  // ----------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic pulse_src(input reset_src_type s);
    src_i = s;
    tick();
    src_i = '0;
  endtask : pulse_src

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    mem_i = {1'b1, 1'b0, a, d};
    tick();
    mem_i = '0;
    tick();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic strobe);
    mem_i = {1'b0, 1'b1, a, 8'h00};
    second_clock_phase_i = strobe;
    tick();
    mem_i = '0;
    second_clock_phase_i = 1'b0;
    tick();
  endtask : rd

  task automatic chk_cold;
    chk("pin_o", 32'hffffffff, pin_o);
    chk("pin_oe_o", 32'h0, pin_oe_o);
    chk("analog_sel", `ANALOG_SEL_RESET, core_o.analog_sel);
    chk("pc", `PC_RESET, {core_o.pc, core_o.pcl});
    chk("wdt", 0, wdt_count_o);
  endtask : chk_cold

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_power_on;
    chk_cold();
    wr(`ADDR_INTC, 8'h81);
    wr(`ADDR_TMC, 8'h42);
    wr(`ADDR_ANALOG_SEL, 8'h00);
    wr(`ADDR_PORT_C_DIR, 8'h00);
    mode_i = HALT_SLEEP;
    pulse_src(3'h1);
    chk("sleep wdt flags", 2'h3, flags);
    tick();
    pulse_src(3'h7);
    mode_i = RUN_NORMAL;
    chk("por flags", 2'h0, flags);
    chk("intc", `INTC_RESET, core_o.intc);
    chk("tmc", `TMC_RESET, core_o.tmc);
    chk("stack", `STACK_TOP, core_o.stack_ptr);
    chk_cold();
    tick(4);
    chk("wdt runs", 1, wdt_count_o != 0);
  endtask : t_power_on

  task automatic t_low_voltage;
    wr(`ADDR_PORT_A_DIR, 8'h00);
    pulse_src(3'h1);
    chk("run wdt flags", 2'h2, flags);
    chk_cold();
    halt_enter_i = 1'b1;
    tick();
    halt_enter_i = 1'b0;
    wr(`ADDR_PORT_A_DIR, 8'h00);
    mode_i = RUN_SLOW;
    pulse_src(3'h2);
    mode_i = RUN_NORMAL;
    chk("lv flags", 2'h3, flags);
    chk("lv flag", 1, lowvolt_reset_flag_o);
    chk_cold();
    tick(3);
    chk("lv flag held", 1, lowvolt_reset_flag_o);
    wr(`ADDR_CTRL, 8'h00);
    chk("lv flag cleared", 0, lowvolt_reset_flag_o);
  endtask : t_low_voltage

  task automatic t_warm;
    wr(`ADDR_PORT_D, 8'h5a);
    wr(`ADDR_PORT_D_DIR, 8'h0f);
    wr(`ADDR_INTC, 8'h33);
    wdt_clear_i = 1'b1;
    tick();
    wdt_clear_i = 1'b0;
    mode_i = HALT_IDLE;
    pulse_src(3'h1);
    mode_i = RUN_NORMAL;
    chk("warm flags", 2'h3, flags);
    chk("warm pc", 0, {core_o.pc, core_o.pcl});
    chk("warm intc", 8'h33, core_o.intc);
    chk("warm port", 16'hf05a, {pin_oe_o[31:24], pin_o[31:24]});
    rd(`ADDR_STATUS, 1'b1);
    chk("status", 8'h30, mem_rdata_o & 8'h30);
    wdt_clear_i = 1'b1;
    tick();
    wdt_clear_i = 1'b0;
    chk("cleared flags", 2'h0, flags);
  endtask : t_warm

  task automatic t_ports;
    wr(`ADDR_PORT_B_DIR, 8'h00);
    wr(`ADDR_PORT_B, 8'hc3);
    pin_i[15:8] = 8'h3c;
    tick(5);
    chk("latch", 16'hffc3, {pin_oe_o[15:8], pin_o[15:8]});
    rd(`ADDR_PORT_B, 1'b1);
    chk("read latch", 8'hc3, mem_rdata_o);
    wr(`ADDR_PORT_B_DIR, 8'hff);
    rd(`ADDR_PORT_B, 1'b1);
    chk("read pin", 8'h3c, mem_rdata_o);
    pin_i[15:8] = 8'h99;
    tick(3);
    rd(`ADDR_PORT_B, 1'b0);
    chk("no strobe", 8'h3c, mem_rdata_o);
  endtask : t_ports

  task automatic report_and_stop;
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #100000;
    failures++;
    report_and_stop();
  end

  initial begin
    tick(5);
    rst_i = 1'b0;
    t_power_on();
    t_low_voltage();
    t_warm();
    t_ports();
    report_and_stop();
  end
endmodule : reset_state_controller_tb
